//--- core/vsgc_pkg.sv
// Package of constants and types for the volume serial gain control
package vsgc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned POR_TIME_MS = 100;
  localparam int unsigned POR_CYCLES = (CLK_HZ / 1000) * POR_TIME_MS;
  localparam int unsigned ZC_TIMEOUT_MS = 16;
  localparam int unsigned ZC_TIMEOUT_CYCLES = (CLK_HZ / 1000) * ZC_TIMEOUT_MS;
  localparam int unsigned CAL_CYCLES_DEF = 1024;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CODE_BITS = 8;
  localparam int unsigned RIGHT_MSB = 15;
  localparam int unsigned LEFT_MSB = 7;
  localparam logic [7:0] CODE_MUTE = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hFF;
  localparam int unsigned TIMER_W = 32;

  typedef enum logic [1:0] {
    VSGC_POR,
    VSGC_CAL,
    VSGC_INIT,
    VSGC_RUN
  } vsgc_state_t;

  // Decoded gain for one channel, in half-dB steps from +31.5 dB
  typedef struct packed {
    logic       mute;
    logic [7:0] atten_half_db;
  } vsgc_gain_t;
endpackage

//--- core/vsgc_channel.sv
// One channel: pending code, zero-crossing wait with timeout, and gain decode
`timescale 1ns/1ns
module vsgc_channel
  import vsgc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = ZC_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] new_code,
  input wire logic zc_enable,
  input wire logic zero_cross,
  output logic [7:0] code_q,
  output vsgc_gain_t gain_q
);
  logic [7:0] pend_q;
  logic wait_q;
  logic [TIMER_W-1:0] tmr_q;
  logic apply;

  // Apply on a rising zero crossing or when the timer expires
  assign apply = wait_q && (zero_cross || tmr_q >= TIMER_W'(TIMEOUT_CYCLES - 1));

  // Only a changed code starts the wait; ZC disabled takes effect at once
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      wait_q <= 1'b0;
      pend_q <= CODE_MUTE;
      tmr_q <= '0;
    end else if (load && new_code != code_q && zc_enable) begin
      wait_q <= 1'b1;
      pend_q <= new_code;
      tmr_q <= '0;
    end else if (apply) begin
      wait_q <= 1'b0;
    end else if (wait_q) begin
      tmr_q <= tmr_q + 1'b1;
    end
  end

  // Active code register
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      code_q <= CODE_MUTE;
    end else if (load && !zc_enable) begin
      code_q <= new_code;
    end else if (apply) begin
      code_q <= pend_q;
    end
  end

  // Gain decode: 0 mutes at unity; else atten = 255 - N half-dB steps below +31.5 dB
  always_ff @(posedge clock) begin
    if (reset) begin
      gain_q <= '{mute: 1'b1, atten_half_db: 8'h00};
    end else begin
      gain_q.mute <= (code_q == CODE_MUTE);
      gain_q.atten_half_db <= (code_q == CODE_MUTE) ? 8'h00 : CODE_MAX - code_q;
    end
  end
endmodule

//--- core/vsgc_top.sv
// Top of the volume serial gain control: serial port, power sequencing, mute
//
// Behaviour
// - Hold reset about 100 ms at power-up, muted.
// - Start offset calibration when power-up reset ends.
// - After power-up calibration both gain codes become zero.
// - Supply low mutes, then reruns power-up.
// - Accept serial bits only while select low.
// - Word is 16 bits: two 8-bit codes.
// - Codes sent MSB first, unsigned binary.
// - Sample serial input on serial clock rise.
// - Serial output high impedance while select high.
// - Serial output carries bits shifted out.
// - Serial output changes on serial clock fall.
// - Code zero mutes channel at unity gain.
// - Gain is 31.5 dB minus half-dB steps.
// - Zero-cross enable input gates zero-cross updates.
// - Wait starts only on code change, per channel.
// - Apply at positive zero crossing or 16 ms.
// - Hardware mute terminates outputs to ground.
// - Hardware mute at zero crossing or timeout.
// - Hardware mute starts offset calibration.
`timescale 1ns/1ns
module vsgc_top
  import vsgc_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_CYCLES,
  parameter int unsigned ZC_CYC = ZC_TIMEOUT_CYCLES,
  parameter int unsigned CAL_CYC = CAL_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic zero_cross_enable,
  input wire logic mute_n,
  input wire logic supply_low,
  input wire logic zc_right,
  input wire logic zc_left,
  output logic serial_out,
  output logic serial_out_oe,
  output logic hw_mute,
  output logic cal_active,
  output vsgc_gain_t gain_right,
  output vsgc_gain_t gain_left,
  output logic [7:0] code_right,
  output logic [7:0] code_left
);
  // Two-flop synchronisers; stage one is read only by stage two
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic sclk_d1_q;
  logic sel_d1_q;
  logic zcr_d1_q;
  logic zcl_d1_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      s1_q <= 8'h09; // Idle: select high, mute released, supply good
      s2_q <= 8'h09;
    end else begin
      s1_q <= {zc_left, zc_right, supply_low, zero_cross_enable, mute_n, serial_in,
               serial_clk, select_n};
      s2_q <= s1_q;
    end
  end

  logic sel_s;
  logic sclk_s;
  logic sdi_s;
  logic mute_n_s;
  logic zero_cross_enable_s;
  logic low_s;
  assign sel_s = s2_q[0];
  assign sclk_s = s2_q[1];
  assign sdi_s = s2_q[2];
  assign mute_n_s = s2_q[3];
  assign zero_cross_enable_s = s2_q[4];
  assign low_s = s2_q[5];

  // Edge history for serial clock, select and the comparator outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      sclk_d1_q <= 1'b0;
      sel_d1_q <= 1'b1;
      zcr_d1_q <= 1'b0;
      zcl_d1_q <= 1'b0;
    end else begin
      sclk_d1_q <= sclk_s;
      sel_d1_q <= sel_s;
      zcr_d1_q <= s2_q[6];
      zcl_d1_q <= s2_q[7];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic sel_rise;
  logic zcr_rise;
  logic zcl_rise;
  assign sclk_rise = sclk_s && !sclk_d1_q;
  assign sclk_fall = !sclk_s && sclk_d1_q;
  assign sel_rise = sel_s && !sel_d1_q;
  // Comparator going high marks a positive-slope zero crossing
  assign zcr_rise = s2_q[6] && !zcr_d1_q;
  assign zcl_rise = s2_q[7] && !zcl_d1_q;

  // Power sequencing
  vsgc_state_t state_q;
  logic [TIMER_W-1:0] seq_q;
  logic mute_n_d1_q;
  logic cal_req;
  assign cal_req = mute_n_d1_q && !mute_n_s;

  always_ff @(posedge clock) begin
    if (reset) begin
      mute_n_d1_q <= 1'b1;
    end else begin
      mute_n_d1_q <= mute_n_s;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || low_s) begin
      state_q <= VSGC_POR;
      seq_q <= '0;
    end else begin
      unique case (state_q)
        VSGC_POR: begin
          if (seq_q >= TIMER_W'(POR_CYC - 1)) begin
            state_q <= VSGC_CAL;
            seq_q <= '0;
          end else begin
            seq_q <= seq_q + 1'b1;
          end
        end
        VSGC_CAL: begin
          if (seq_q >= TIMER_W'(CAL_CYC - 1)) begin
            state_q <= VSGC_INIT;
            seq_q <= '0;
          end else begin
            seq_q <= seq_q + 1'b1;
          end
        end
        VSGC_INIT: begin
          state_q <= VSGC_RUN;
        end
        VSGC_RUN: begin
          if (cal_req) begin
            state_q <= VSGC_CAL;
            seq_q <= '0;
          end
        end
      endcase
    end
  end

  logic in_por;
  assign in_por = (state_q == VSGC_POR);

  // Marks a calibration that followed power-up; a mute calibration must keep the codes
  logic from_por_q;
  always_ff @(posedge clock) begin
    if (reset || low_s || in_por) begin
      from_por_q <= 1'b1;
    end else if (state_q == VSGC_RUN) begin
      from_por_q <= 1'b0;
    end
  end

  // Serial shift register: sample on rise, MSB first, right code first
  logic [WORD_BITS-1:0] shift_q;
  always_ff @(posedge clock) begin
    if (reset || in_por) begin
      shift_q <= '0;
    end else if (!sel_s && sclk_rise) begin
      shift_q <= {shift_q[WORD_BITS-2:0], sdi_s};
    end
  end

  // Serial output follows the bit leaving the register, updated on the fall
  always_ff @(posedge clock) begin
    if (reset || in_por) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= !sel_s;
      if (!sel_s && sclk_fall) begin
        serial_out <= shift_q[WORD_BITS-1];
      end
    end
  end

  // Codes transfer on select rise; ignored until the init state has passed
  logic load;
  logic clear;
  assign load = sel_rise && (state_q == VSGC_RUN);
  assign clear = in_por || (state_q == VSGC_INIT && from_por_q);

  logic [7:0] code_r;
  logic [7:0] code_l;
  vsgc_gain_t gain_r;
  vsgc_gain_t gain_l;

  vsgc_channel #(
    .TIMEOUT_CYCLES(ZC_CYC)
  ) u_right (
    .clock(clock),
    .reset(reset),
    .clear(clear),
    .load(load),
    .new_code(shift_q[RIGHT_MSB -: CODE_BITS]),
    .zc_enable(zero_cross_enable_s),
    .zero_cross(zcr_rise),
    .code_q(code_r),
    .gain_q(gain_r)
  );

  vsgc_channel #(
    .TIMEOUT_CYCLES(ZC_CYC)
  ) u_left (
    .clock(clock),
    .reset(reset),
    .clear(clear),
    .load(load),
    .new_code(shift_q[LEFT_MSB -: CODE_BITS]),
    .zc_enable(zero_cross_enable_s),
    .zero_cross(zcl_rise),
    .code_q(code_l),
    .gain_q(gain_l)
  );

  // Hardware mute: entering waits for a zero crossing or timeout, regardless of enable
  logic mute_wait_q;
  logic [TIMER_W-1:0] mtmr_q;
  always_ff @(posedge clock) begin
    if (reset || in_por) begin
      hw_mute <= 1'b1;
      mute_wait_q <= 1'b0;
      mtmr_q <= '0;
    end else if (mute_n_s) begin
      hw_mute <= 1'b0;
      mute_wait_q <= 1'b0;
      mtmr_q <= '0;
    end else if (!hw_mute) begin
      if (mute_wait_q && (zcr_rise || zcl_rise || mtmr_q >= TIMER_W'(ZC_CYC - 1))) begin
        hw_mute <= 1'b1;
        mute_wait_q <= 1'b0;
      end else begin
        mute_wait_q <= 1'b1;
        mtmr_q <= mute_wait_q ? mtmr_q + 1'b1 : '0;
      end
    end
  end

  // Registered status and gain outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      cal_active <= 1'b0;
      gain_right <= '{mute: 1'b1, atten_half_db: 8'h00};
      gain_left <= '{mute: 1'b1, atten_half_db: 8'h00};
      code_right <= CODE_MUTE;
      code_left <= CODE_MUTE;
    end else begin
      cal_active <= (state_q == VSGC_CAL);
      gain_right <= gain_r;
      gain_left <= gain_l;
      code_right <= code_r;
      code_left <= code_l;
    end
  end
endmodule

//--- sim/vsgc_chk.sv
// Concurrent checks on the ports of the serial gain control top
`timescale 1ns/1ns
module vsgc_chk
  import vsgc_pkg::*;
#(
  parameter int POR_CYC = 100,
  parameter int ZC_CYC = 50,
  parameter int CAL_CYC = 20
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic zero_cross_enable,
  input wire logic mute_n,
  input wire logic supply_low,
  input wire logic zc_right,
  input wire logic zc_left,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic hw_mute,
  input wire logic cal_active,
  input wire vsgc_gain_t gain_right,
  input wire vsgc_gain_t gain_left,
  input wire logic [7:0] code_right,
  input wire logic [7:0] code_left
);
  localparam int POR_LO = POR_CYC - 4;
  localparam int ZC_MAX = ZC_CYC + 8;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Pin checks; the windows allow for the pin synchronisers
  property p_oe_off; select_n [*6] |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe while deselected");
  property p_sout; $changed(serial_out) && $past(serial_out_oe) |-> !serial_clk; endproperty
  a_sout: assert property (p_sout) else $error("serial out moved on rise");
  property p_load; $changed(code_right) |-> select_n; endproperty
  a_load: assert property (p_load) else $error("code moved mid frame");
  // Power sequencing and mute
  property p_cal_go; $fell(reset) |-> ##POR_LO !cal_active ##[1:12] cal_active; endproperty
  a_cal_go: assert property (p_cal_go) else $error("calibration start");
  property p_supply; supply_low [*6] |-> hw_mute; endproperty
  a_supply: assert property (p_supply) else $error("no mute on supply low");
  property p_hwm; $fell(mute_n) |-> ##[1:ZC_MAX] hw_mute; endproperty
  a_hwm: assert property (p_hwm) else $error("hardware mute late");
  // Decode follows the active code once settled
  property p_zmute; $stable(code_right) [*2] |-> gain_right.mute == (code_right == 8'h00);
  endproperty
  a_zmute: assert property (p_zmute) else $error("mute decode");
  property p_atten;
    $stable(code_left) [*2] && code_left != 8'h00 |-> gain_left.atten_half_db == 8'hFF - code_left;
  endproperty
  a_atten: assert property (p_atten) else $error("gain decode");
endmodule
bind vsgc_top vsgc_chk #(.POR_CYC(POR_CYC), .ZC_CYC(ZC_CYC), .CAL_CYC(CAL_CYC)) i_chk (.*);

//--- sim/vsgc_host.sv
// Behavioural host on the three-wire serial port
`timescale 1ns/1ns
module vsgc_host (
  output logic select_n,
  output logic serial_clk,
  output logic serial_in,
  input wire logic sout
);
  logic [31:0] got;
  // Serial clock idles low between frames
  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
    got = '0;
  end
  // Sends n bits MSB first; sel low clocks with select high to probe refusal
  task automatic xfer(input logic [31:0] w, input int n, input logic sel);
    select_n = ~sel;
    #100;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #62 serial_clk = 1'b1;
      got = {got[30:0], sout};
      #63 serial_clk = 1'b0;
    end
    #40 select_n = 1'b1;
    serial_in = ~serial_in;
  endtask
endmodule

//--- sim/vsgc_tb.sv
// Self-checking bench for the serial gain control
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("ERROR %0t mismatch", $time); end end
module tb;
  import vsgc_pkg::*;
  logic clock, reset, zero_cross_enable, mute_n, supply_low, zc_right, zc_left;
  logic select_n, serial_clk, serial_in, serial_out, serial_out_oe, hw_mute, cal_active;
  logic [7:0] code_right, code_left;
  vsgc_gain_t gain_right, gain_left;
  wire so_pin = serial_out_oe ? serial_out : 1'bz;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] q[$];
  logic [15:0] w, prev;
  vsgc_top #(.POR_CYC(100), .ZC_CYC(50), .CAL_CYC(20)) i_dut (.*);
  vsgc_host i_host (.sout(so_pin), .*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      $display("ERROR %0t timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Model: right code in the high byte, attenuation is 255 minus code in half dB
  task automatic chk_ch(input logic [15:0] e);
    `CHK(code_right, e[15:8])
    `CHK(code_left, e[7:0])
    `CHK(gain_right.mute, e[15:8] == 8'h00)
    if (e[7:0] != 8'h00) `CHK(gain_left.atten_half_db, 8'hFF - e[7:0])
    `CHK(gain_left.mute, e[7:0] == 8'h00)
    if (e[15:8] != 8'h00) `CHK(gain_right.atten_half_db, 8'hFF - e[15:8])
  endtask
  // Waits out reset and calibration; bounded so a stuck sequencer fails
  task automatic pwr_up();
    int n;
    n = 0;
    while (cal_active !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    while (cal_active !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    tick(4);
    `CHK(n < 400, 1'b1)
    `CHK(hw_mute, 1'b0)
    chk_ch(16'h0000);
  endtask
  initial begin
    reset = 1'b1;
    zero_cross_enable = 1'b0;
    mute_n = 1'b1;
    supply_low = 1'b0;
    zc_right = 1'b0;
    zc_left = 1'b0;
    void'($urandom(32'h9EA11E20));
    tick(3);
    reset <= 1'b0;
    pwr_up();
    // Boundary codes, then random ones, applied at once
    q = '{16'h00FF, 16'h0100, 16'hFF01};
    repeat (3) q.push_back(16'($urandom()));
    foreach (q[i]) begin
      i_host.xfer({16'h0000, q[i]}, 16, 1'b1);
      tick(10);
      chk_ch(q[i]);
    end
    // Clocks while deselected are ignored; then a two-device chain
    prev = q[$];
    i_host.xfer(32'hFFFFFFFF, 16, 1'b0);
    w = 16'($urandom());
    i_host.xfer({16'h5AC3, w}, 32, 1'b1);
    tick(10);
    `CHK(i_host.got, {prev, 16'h5AC3})
    chk_ch(w);
    // Gated change: right waits for its crossing, left for the timeout
    zero_cross_enable <= 1'b1;
    prev = w;
    w = ~prev;
    i_host.xfer({16'h0000, w}, 16, 1'b1);
    tick(10);
    `CHK(code_right, prev[15:8])
    zc_right <= 1'b1;
    tick(8);
    `CHK(code_right, w[15:8])
    `CHK(code_left, prev[7:0])
    tick(60);
    chk_ch(w);
    zc_right <= 1'b0;
    // Hardware mute lands on a crossing even with gating off
    zero_cross_enable <= 1'b0;
    mute_n <= 1'b0;
    tick(8);
    `CHK(cal_active, 1'b1)
    zc_left <= 1'b1;
    tick(6);
    `CHK(hw_mute, 1'b1)
    tick(30);
    mute_n <= 1'b1;
    tick(8);
    `CHK(hw_mute, 1'b0)
    chk_ch(w);
    supply_low <= 1'b1;
    tick(8);
    `CHK(hw_mute, 1'b1)
    supply_low <= 1'b0;
    pwr_up();
    close_out();
  end
endmodule
